// file: plc_compressor.sv
/*
 * piecewise-linear logarithmic compressor: each input sample is offset
 * compensated, rectified, mapped through six line segments and queued
 * for the d/a stage, which takes one word per sample period.
 * assumes samples arrive from logic on the same clock with valid/ready,
 * and that the d/a stage latches dac_data_o on dac_strobe_o.
 */
`timescale 1ns/100ps
`include "plc_defines.svh"

// Function
// R1 - output between zero and full scale, log scaled
// R2 - rectify sample before any segment math
// R3 - always compute lowest segment, 12.75 times input
// R4 - copy rectified input into output conversion register
// R5 - test bits three to seven ascending, else idle
// R6 - set bit overwrites result with its segment
// R7 - no bit set keeps lowest segment result
// R8 - bit three: four times input plus 0.270
// R9 - bit four: twice input plus 0.391
// R10 - bit five: input plus 0.516
// R11 - bit six: half input plus 0.641
// R12 - bit seven: 0.219 input plus 0.781
// R13 - final result goes to output conversion register
// R14 - add offset compensation constant before compression
// R15 - segment edges at powers of two
// R16 - tested bit k weighs two to k minus 8
// R17 - one full sequence and output per sample
module plc_compressor #(
    parameter int SAMPLE_DIV = `PLC_SAMPLE_DIV,
    parameter int FIFO_DEPTH = `PLC_FIFO_DEPTH
) (
    // clock and reset
    input  wire logic                  clk_i,
    input  wire logic                  rst_n_i,
    // sample stream from the front end
    input  wire logic [`PLC_IN_W-1:0]  input_sample_i,
    input  wire logic                  sample_valid_i,
    output logic                       sample_ready_o,
    // static offset compensation, two's complement
    input  wire logic [`PLC_IN_W-1:0]  offset_comp_i,
    // d/a stage
    output logic [`PLC_OUT_W-1:0]      dac_data_o,
    output logic [`PLC_SEG_W-1:0]      dac_seg_o,
    output logic                       dac_clip_o,
    output logic                       dac_strobe_o,
    output logic                       dac_underrun_o,
    // observation
    output logic [`PLC_OUT_W-1:0]      output_conversion_register_o,
    output logic                       busy_o
);
    localparam int FW = `PLC_OUT_W + `PLC_SEG_W + 1;

    // the sequence takes eleven cycles; a shorter period would let the
    // fifo run dry every sample and the d/a stage would keep underrunning
    if (SAMPLE_DIV < 12) begin : g_bad_div
        $error("plc_compressor: SAMPLE_DIV must be at least 12");
    end

    plc_pkg::plc_state_t s;
    plc_pkg::plc_state_t next_s;

    logic                 tick;
    logic [FW-1:0]        fifo_in_data;
    logic                 fifo_in_valid;
    logic                 fifo_in_ready;
    logic [FW-1:0]        fifo_out_data;
    logic                 fifo_out_valid;
    logic                 cond_bit_three;
    logic                 cond_bit_seven;
    logic                 cond_tested;
    logic [`PLC_ACC_W-1:0] log_result;

    // segment value in q.16 for a magnitude in q.8; idx is the tested
    // bit, or the base code for the lowest range; multiplies are shift
    // and add so the whole segment fits one cycle
    function automatic logic [`PLC_ACC_W-1:0] seg_calc(
        input logic [2:0]            idx,
        input logic [`PLC_MAG_W-1:0] x
    );
        logic [`PLC_ACC_W-1:0] xq;
        xq = {2'h0, x, 8'h00};                                   // [R16]
        unique case (idx)
            3'h3:    seg_calc = (xq << 2) + `PLC_K_BIT3;         // [R8]
            3'h4:    seg_calc = (xq << 1) + `PLC_K_BIT4;         // [R9]
            3'h5:    seg_calc = xq + `PLC_K_BIT5;                // [R10]
            3'h6:    seg_calc = (xq >> 1) + `PLC_K_BIT6;         // [R11]
            3'h7:    seg_calc = (xq >> 3) + (xq >> 4) + (xq >> 5)
                                + `PLC_K_BIT7;                   // [R12]
            // 12.75 = 8 + 4 + 0.5 + 0.25
            default: seg_calc = (xq << 3) + (xq << 2) + (xq >> 1)
                                + (xq >> 2);                     // [R3]
        endcase
    endfunction : seg_calc

    // rectify the compensated sum and clamp it just below full scale
    // so that every nonzero top-range input still sets bit seven
    function automatic logic [`PLC_MAG_W-1:0] rectify(
        input logic [`PLC_SUM_W-1:0] v
    );
        logic [`PLC_SUM_W-1:0] m;
        m = v[`PLC_SUM_W-1] ? (~v + 1'b1) : v;                   // [R2]
        if (m > {3'h0, `PLC_MAG_MAX}) begin
            rectify = `PLC_MAG_MAX;
        end else begin
            rectify = m[`PLC_MAG_W-1:0];
        end
    endfunction : rectify

    // round q.16 to q.8 and hold the result inside full scale
    function automatic logic [`PLC_OUT_W:0] round_sat(
        input logic [`PLC_ACC_W-1:0] a
    );
        logic [`PLC_SUM_W-1:0] r;
        r = {1'b0, a[`PLC_ACC_W-1:8]} + {10'h000, a[7]};
        if (r > `PLC_FULL_SCALE) begin
            round_sat = {1'b1, `PLC_FULL_OUT};                   // [R1]
        end else begin
            round_sat = {1'b0, r[`PLC_OUT_W-1:0]};
        end
    endfunction : round_sat

    // names for the conditions read from the conversion register
    assign cond_bit_three = s.ocr[3];
    assign cond_bit_seven = s.ocr[7];
    assign cond_tested    = s.ocr[s.bit_idx];                    // [R15]
    assign log_result     = s.acc;

    // fifo word: clip flag, segment code, value
    assign fifo_in_data  = {s.clip, s.seg, s.ocr};
    assign fifo_in_valid = (s.state == plc_pkg::st_push);

    // sequencer and d/a stage next state
    always_comb begin
        logic [`PLC_OUT_W:0]   rs;
        logic [`PLC_SUM_W-1:0] sum;
        next_s            = s;
        next_s.dac_strobe = 1'b0;
        next_s.underrun   = 1'b0;
        rs                = round_sat(s.acc);
        sum               = {input_sample_i[`PLC_IN_W-1], input_sample_i}
                            + {offset_comp_i[`PLC_IN_W-1], offset_comp_i};

        unique case (s.state)
            // take a sample with its compensation already added
            plc_pkg::st_idle: begin
                if (sample_valid_i) begin
                    next_s.x_raw = sum;                          // [R14]
                    next_s.state = plc_pkg::st_rect;
                end
            end
            // absolute value before any segment is formed
            plc_pkg::st_rect: begin
                next_s.x_mag = rectify(s.x_raw);                 // [R2]
                next_s.state = plc_pkg::st_base;
            end
            // lowest range first, whatever the amplitude
            plc_pkg::st_base: begin
                next_s.acc   = seg_calc(`PLC_SEG_BASE, s.x_mag); // [R3]
                next_s.seg   = `PLC_SEG_BASE;
                next_s.state = plc_pkg::st_load;
            end
            // the rectified input becomes the condition source
            plc_pkg::st_load: begin
                next_s.ocr     = {1'b0, s.x_mag};                // [R4]
                next_s.bit_idx = `PLC_FIRST_BIT;
                next_s.state   = plc_pkg::st_test;
            end
            // one bit per cycle, small ranges first; a clear bit is a
            // no-operation cycle so every sample takes the same time
            plc_pkg::st_test: begin
                if (cond_tested) begin                           // [R5]
                    next_s.acc = seg_calc(s.bit_idx, s.x_mag);   // [R6]
                    next_s.seg = s.bit_idx - 3'h2;
                end
                if (s.bit_idx == `PLC_LAST_BIT) begin
                    next_s.state = plc_pkg::st_final;            // [R7]
                end else begin
                    next_s.bit_idx = s.bit_idx + 3'h1;
                end
            end
            // the final value replaces the conditions in the register
            plc_pkg::st_final: begin
                next_s.ocr   = rs[`PLC_OUT_W-1:0];               // [R13]
                next_s.clip  = rs[`PLC_OUT_W];
                next_s.state = plc_pkg::st_push;
            end
            // wait for room; a full queue stalls the next sample
            plc_pkg::st_push: begin
                if (fifo_in_ready) begin
                    next_s.state = plc_pkg::st_idle;             // [R17]
                end
            end
        endcase

        // d/a stage takes exactly one word per sample period; with none
        // queued it keeps the last value and flags the gap
        if (tick) begin
            if (fifo_out_valid) begin
                next_s.dac_data   = fifo_out_data[`PLC_OUT_W-1:0];
                next_s.dac_seg    = fifo_out_data[FW-2:`PLC_OUT_W];
                next_s.dac_clip   = fifo_out_data[FW-1];
                next_s.dac_strobe = 1'b1;                        // [R17]
            end else begin
                next_s.underrun = 1'b1;
            end
        end
    end

    // state register
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s.state      <= plc_pkg::st_idle;
            s.x_raw      <= '0;
            s.x_mag      <= '0;
            s.ocr        <= `PLC_OCR_RST;
            s.acc        <= `PLC_ACC_RST;
            s.bit_idx    <= `PLC_FIRST_BIT;
            s.seg        <= `PLC_SEG_BASE;
            s.clip       <= 1'b0;
            s.dac_data   <= `PLC_OCR_RST;
            s.dac_seg    <= `PLC_SEG_BASE;
            s.dac_clip   <= 1'b0;
            s.dac_strobe <= 1'b0;
            s.underrun   <= 1'b0;
        end else begin
            s <= next_s;
        end
    end

    // sample period enable for the d/a stage
    plc_tick #(
        .DIV (SAMPLE_DIV)
    ) u_tick (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .tick_o  (tick)
    );

    // results queue between the sequencer and the d/a stage; it drains
    // only on the sample enable, so a fast source really fills it
    plc_fifo #(
        .WIDTH (FW),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_i       (clk_i),
        .rst_n_i     (rst_n_i),
        .in_data_i   (fifo_in_data),
        .in_valid_i  (fifo_in_valid),
        .in_ready_o  (fifo_in_ready),
        .out_data_o  (fifo_out_data),
        .out_valid_o (fifo_out_valid),
        .out_ready_i (tick)
    );

    // outputs straight from the state record
    assign sample_ready_o               = (s.state == plc_pkg::st_idle);
    assign busy_o                       = (s.state != plc_pkg::st_idle);
    assign output_conversion_register_o = s.ocr;
    assign dac_data_o                   = s.dac_data;
    assign dac_seg_o                    = s.dac_seg;
    assign dac_clip_o                   = s.dac_clip;
    assign dac_strobe_o                 = s.dac_strobe;
    assign dac_underrun_o               = s.underrun;

endmodule : plc_compressor

// file: plc_compressor_asserts.sv
/*
 * concurrent checks on the compressor ports, bound into plc_compressor.
 * assumes plc_tb_pkg compiled first; one clock, async active-low reset.
 */
`timescale 1ns/100ps
`include "plc_defines.svh"

module plc_compressor_asserts #(
    parameter int SAMPLE_DIV = `PLC_SAMPLE_DIV,
    parameter int FIFO_DEPTH = `PLC_FIFO_DEPTH
) (
    // clock and reset
    input wire logic                 clk_i,
    input wire logic                 rst_n_i,
    // sample side
    input wire logic [`PLC_IN_W-1:0] input_sample_i,
    input wire logic                 sample_valid_i,
    input wire logic                 sample_ready_o,
    input wire logic [`PLC_IN_W-1:0] offset_comp_i,
    // d/a side and observation
    input wire logic [`PLC_OUT_W-1:0] dac_data_o,
    input wire logic [`PLC_SEG_W-1:0] dac_seg_o,
    input wire logic                  dac_clip_o,
    input wire logic                  dac_strobe_o,
    input wire logic                  dac_underrun_o,
    input wire logic [`PLC_OUT_W-1:0] output_conversion_register_o,
    input wire logic                  busy_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    // reference values of the sample now
    logic       take;
    logic [7:0] mag_c;
    logic [8:0] out_c;
    assign take  = sample_valid_i && sample_ready_o;
    assign mag_c = plc_tb_pkg::plc_mag(input_sample_i, offset_comp_i);
    assign out_c = plc_tb_pkg::plc_expect(input_sample_i, offset_comp_i) >> 0;

    // cycles since the last strobe, saturating
    int gap;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) gap <= SAMPLE_DIV;
        else if (dac_strobe_o) gap <= 1;
        else if (gap < SAMPLE_DIV) gap <= gap + 1;
    end

    property p_range;
        dac_data_o <= `PLC_FULL_OUT && output_conversion_register_o <= `PLC_FULL_OUT;
    endproperty
    a_range: assert property (p_range) else $error("result above full scale");
    property p_ready_idle;
        $fell(sample_ready_o) |-> $past(sample_valid_i);
    endproperty
    a_ready_idle: assert property (p_ready_idle) else $error("ready not idle");
    property p_walk;
        take |=> !sample_ready_o [*8] ##1 !sample_ready_o [*2];
    endproperty
    a_walk: assert property (p_walk) else $error("sequence too short");
    property p_load;
        take |-> ##4 output_conversion_register_o == {1'b0, $past(mag_c, 4)};
    endproperty
    a_load: assert property (p_load) else $error("rectified load wrong");
    property p_final;
        take |-> ##10 output_conversion_register_o == $past(out_c, 10);
    endproperty
    a_final: assert property (p_final) else $error("final result wrong");
    property p_gap;
        dac_strobe_o |-> gap >= SAMPLE_DIV;
    endproperty
    a_gap: assert property (p_gap) else $error("strobes too close");
    property p_pulse;
        dac_strobe_o |=> !dac_strobe_o && !dac_underrun_o;
    endproperty
    a_pulse: assert property (p_pulse) else $error("strobe longer than one cycle");
    property p_excl;
        !(dac_strobe_o && dac_underrun_o);
    endproperty
    a_excl: assert property (p_excl) else $error("strobe with underrun");
    property p_hold;
        !dac_strobe_o |-> $stable(dac_data_o) && $stable(dac_seg_o);
    endproperty
    a_hold: assert property (p_hold) else $error("word changed without strobe");

    c_take: cover property (take);
    c_strobe: cover property (dac_strobe_o);
    c_under: cover property (dac_underrun_o);
    c_stall: cover property (sample_valid_i && !sample_ready_o [*8]);
endmodule : plc_compressor_asserts

bind plc_compressor plc_compressor_asserts #(
    .SAMPLE_DIV(SAMPLE_DIV),
    .FIFO_DEPTH(FIFO_DEPTH)
) u_plc_compressor_asserts (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .input_sample_i(input_sample_i),
    .sample_valid_i(sample_valid_i), .sample_ready_o(sample_ready_o),
    .offset_comp_i(offset_comp_i), .dac_data_o(dac_data_o), .dac_seg_o(dac_seg_o),
    .dac_clip_o(dac_clip_o), .dac_strobe_o(dac_strobe_o), .dac_underrun_o(dac_underrun_o),
    .output_conversion_register_o(output_conversion_register_o), .busy_o(busy_o)
);

// file: plc_compressor_tb.sv
/*
 * self-checking bench of plc_compressor with a d/a model on its far side.
 * assumes plc_tb_pkg, plc_dac_model and the design compiled first.
 */
`timescale 1ns/100ps
`include "plc_defines.svh"

module plc_compressor_tb;
    localparam int DIV   = 40;    // slow enough that a burst fills the queue
    localparam int LIMIT = 20000;

    logic                  clk_i, rst_n_i, sample_valid_i;
    logic [`PLC_IN_W-1:0]  input_sample_i, offset_comp_i;
    logic [`PLC_OUT_W-1:0] dac_data_o, output_conversion_register_o;
    logic [`PLC_SEG_W-1:0] dac_seg_o;
    logic                  sample_ready_o, dac_clip_o, dac_strobe_o, dac_underrun_o, busy_o;
    int                    num_errors = 0, checked = 0, cycles = 0, low_run = 0, max_low = 0;

    plc_compressor #(.SAMPLE_DIV(DIV), .FIFO_DEPTH(8)) u_plc_compressor (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .input_sample_i(input_sample_i),
        .sample_valid_i(sample_valid_i), .sample_ready_o(sample_ready_o),
        .offset_comp_i(offset_comp_i), .dac_data_o(dac_data_o), .dac_seg_o(dac_seg_o),
        .dac_clip_o(dac_clip_o), .dac_strobe_o(dac_strobe_o), .dac_underrun_o(dac_underrun_o),
        .output_conversion_register_o(output_conversion_register_o), .busy_o(busy_o));
    plc_dac_model u_plc_dac_model (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .dac_data_i(dac_data_o), .dac_seg_i(dac_seg_o),
        .dac_clip_i(dac_clip_o), .dac_strobe_i(dac_strobe_o), .dac_underrun_i(dac_underrun_o));

    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    // hang guard and longest refusal run of the sample port
    always @(posedge clk_i) begin
        cycles++;
        low_run <= sample_ready_o ? 0 : low_run + 1;
        if (low_run > max_low) max_low <= low_run;
        if (cycles == LIMIT) begin
            num_errors++;
            final_report();
        end
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // offer one sample and hold it until the taking edge has passed
    task automatic drive_sample(input logic [9:0] smp, input logic [9:0] off);
        int n;
        n = 0;
        @(posedge clk_i);
        input_sample_i <= smp;
        offset_comp_i  <= off;
        sample_valid_i <= 1'b1;
        do begin @(negedge clk_i); n++; end while (!sample_ready_o && n < 400);
        @(posedge clk_i);
        sample_valid_i <= 1'b0;
    endtask : drive_sample

    task automatic expect_word(input logic [9:0] smp, input logic [9:0] off);
        int          n;
        logic [12:0] got;
        n = 0;
        got = 'x;
        while (u_plc_dac_model.words.size() == 0 && n < 4 * DIV) begin
            @(negedge clk_i);
            n++;
        end
        if (u_plc_dac_model.words.size() > 0) got = u_plc_dac_model.words.pop_front();
        chk($sformatf("word %h", smp), {1'b0, plc_tb_pkg::plc_expect(smp, off)}, got);
    endtask : expect_word

    task automatic t_idle_state();
        @(negedge clk_i);
        chk("idle", 22'h200000, {sample_ready_o, busy_o, dac_strobe_o, dac_underrun_o,
            dac_data_o, output_conversion_register_o});
    endtask : t_idle_state

    // every range, its edges, negatives, clamp and offset compensation
    task automatic t_ranges();
        logic [9:0] smp[18] = '{10'h000, 10'h001, 10'h007, 10'h008, 10'h00f, 10'h010,
            10'h01f, 10'h020, 10'h03f, 10'h040, 10'h07f, 10'h080, 10'h0ff, 10'h3f8,
            10'h338, 10'h200, 10'h3fd, 10'h0fc};
        logic [9:0] off[18] = '{10'h005, 10'h000, 10'h000, 10'h000, 10'h000, 10'h000,
            10'h000, 10'h000, 10'h000, 10'h000, 10'h000, 10'h000, 10'h000, 10'h000,
            10'h000, 10'h000, 10'h00a, 10'h3f4};
        foreach (smp[i]) begin
            drive_sample(smp[i], off[i]);
            expect_word(smp[i], off[i]);
        end
    endtask : t_ranges

    // back to back samples fill the queue and stall the sample port; order kept
    task automatic t_burst();
        max_low = 0;
        for (int i = 0; i < 20; i++) drive_sample(10'(i * 12), 10'h000);
        chk("stall", 1, max_low > 11);
        for (int i = 0; i < 20; i++) expect_word(10'(i * 12), 10'h000);
    endtask : t_burst

    // empty queue gives underruns and no words
    task automatic t_underrun();
        int u;
        u = u_plc_dac_model.under_cnt;
        repeat (3 * DIV) @(negedge clk_i);
        chk("underruns", 1, u_plc_dac_model.under_cnt - u >= 2);
        chk("spurious", 0, u_plc_dac_model.words.size());
    endtask : t_underrun

    // reset in mid-sample returns to idle, then work resumes
    task automatic t_mid_reset();
        drive_sample(10'h0c0, 10'h000);
        repeat (3) @(posedge clk_i);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        t_idle_state();
        drive_sample(10'h060, 10'h000);
        expect_word(10'h060, 10'h000);
    endtask : t_mid_reset

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : final_report

    initial begin
        rst_n_i        = 1'b0;
        sample_valid_i = 1'b0;
        input_sample_i = '0;
        offset_comp_i  = '0;
        repeat (5) @(posedge clk_i);
        rst_n_i <= 1'b1;
        t_idle_state();
        t_ranges();
        t_burst();
        t_underrun();
        t_mid_reset();
        final_report();
    end
endmodule : plc_compressor_tb

// file: plc_dac_model.sv
/*
 * d/a stage model: latches each word on the strobe into a queue.
 * assumes the compressor's d/a outputs on the same clock.
 */
`timescale 1ns/100ps
`include "plc_defines.svh"

module plc_dac_model (
    // clock and reset
    input wire logic                  clk_i,
    input wire logic                  rst_n_i,
    // d/a word
    input wire logic [`PLC_OUT_W-1:0] dac_data_i,
    input wire logic [`PLC_SEG_W-1:0] dac_seg_i,
    input wire logic                  dac_clip_i,
    input wire logic                  dac_strobe_i,
    input wire logic                  dac_underrun_i
);
    logic [12:0] words[$];
    int          under_cnt = 0;

    // the converter takes exactly one word per strobe, never more
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            words.delete();
            under_cnt = 0;
        end else begin
            if (dac_strobe_i) words.push_back({dac_clip_i, dac_seg_i, dac_data_i});
            if (dac_underrun_i) under_cnt++;
        end
    end
endmodule : plc_dac_model

// file: plc_defines.svh
/*
 * constants of the piecewise log compressor: field positions, offsets of
 * the line segments in q.16 form, reset values and default counts.
 * assumes it is included by bare name and holds definitions only.
 */
`ifndef PLC_DEFINES_SVH
`define PLC_DEFINES_SVH

// sample and result widths
`define PLC_IN_W         10
`define PLC_SUM_W        11
`define PLC_MAG_W        8
`define PLC_OUT_W        9
`define PLC_ACC_W        18
`define PLC_SEG_W        3

// tested magnitude bits, low range first
`define PLC_FIRST_BIT    3'h3
`define PLC_LAST_BIT     3'h7
`define PLC_SEG_BASE     3'h0

// magnitude clamp and output full scale (1.0 = 0x100)
`define PLC_MAG_MAX      8'hff
`define PLC_FULL_SCALE   11'h100
`define PLC_FULL_OUT     9'h100

// segment offsets as fractions of full scale in q.16
`define PLC_K_BIT3       18'h0451f
`define PLC_K_BIT4       18'h06419
`define PLC_K_BIT5       18'h08419
`define PLC_K_BIT6       18'h0a418
`define PLC_K_BIT7       18'h0c7f0

// reset values
`define PLC_OCR_RST      9'h000
`define PLC_ACC_RST      18'h00000

// default cycles per sample period and fifo depth
`define PLC_SAMPLE_DIV   64
`define PLC_FIFO_DEPTH   8

`endif

// file: plc_fifo.sv
/*
 * synchronous fifo with a registered output word and valid/ready on
 * both sides; DEPTH words of storage plus the output register.
 * assumes a single clock and an asynchronous active-low reset.
 */
`timescale 1ns/100ps
`include "plc_defines.svh"

module plc_fifo #(
    parameter int WIDTH = 13,
    parameter int DEPTH = `PLC_FIFO_DEPTH
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    // filling side
    input  wire logic [WIDTH-1:0] in_data_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    // draining side
    output logic [WIDTH-1:0]      out_data_o,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic             push;
    logic             pop;

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("plc_fifo: DEPTH must be a power of two, at least 2");
    end

    // full only when storage is full, head register not counted
    assign in_ready_o = (count != FULL);
    assign push       = in_valid_i && in_ready_o;
    assign pop        = (count != '0) && (!out_valid_o || out_ready_i);

    // storage array has no reset, it is qualified by count
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    // pointers, count and the registered head word
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ptr      <= '0;
            rd_ptr      <= '0;
            count       <= '0;
            out_data_o  <= '0;
            out_valid_o <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr     <= rd_ptr + 1'b1;
                out_data_o <= mem[rd_ptr];
            end
            if (pop) begin
                out_valid_o <= 1'b1;
            end else if (out_ready_i) begin
                out_valid_o <= 1'b0;
            end
            count <= count + (AW + 1)'(push) - (AW + 1)'(pop);
        end
    end

endmodule : plc_fifo

// file: plc_pkg.sv
/*
 * types of the piecewise log compressor: sequencer states and the packed
 * state record of the top module.
 * assumes plc_defines.svh is reachable on the include path.
 */
`include "plc_defines.svh"

package plc_pkg;

    // one step of the per-sample sequence
    typedef enum logic [2:0] {
        st_idle,
        st_rect,
        st_base,
        st_load,
        st_test,
        st_final,
        st_push
    } plc_step_t;

    // whole state of the compressor
    typedef struct packed {
        plc_step_t                state;
        logic [`PLC_SUM_W-1:0]    x_raw;
        logic [`PLC_MAG_W-1:0]    x_mag;
        logic [`PLC_OUT_W-1:0]    ocr;
        logic [`PLC_ACC_W-1:0]    acc;
        logic [2:0]               bit_idx;
        logic [`PLC_SEG_W-1:0]    seg;
        logic                     clip;
        logic [`PLC_OUT_W-1:0]    dac_data;
        logic [`PLC_SEG_W-1:0]    dac_seg;
        logic                     dac_clip;
        logic                     dac_strobe;
        logic                     underrun;
    } plc_state_t;

endpackage : plc_pkg

// file: plc_tb_pkg.sv
/*
 * reference arithmetic of the log compressor for the checker and bench.
 * assumes plc_defines.svh is on the include path.
 */
`include "plc_defines.svh"

package plc_tb_pkg;

    // offset added, rectified, clamped just below full scale
    function automatic logic [7:0] plc_mag(input logic [9:0] smp, input logic [9:0] off);
        int s;
        s = $signed(smp) + $signed(off);
        if (s < 0) s = -s;
        return (s > 255) ? 8'hff : s[7:0];
    endfunction : plc_mag

    // {seg, out}: highest set bit of 3..7 picks the segment, q.16 then rounded
    function automatic logic [11:0] plc_expect(input logic [9:0] smp, input logic [9:0] off);
        int m, acc, seg, out;
        m = plc_mag(smp, off);
        if (m[7]) begin acc = m * 56 + `PLC_K_BIT7; seg = 5; end
        else if (m[6]) begin acc = m * 128 + `PLC_K_BIT6; seg = 4; end
        else if (m[5]) begin acc = m * 256 + `PLC_K_BIT5; seg = 3; end
        else if (m[4]) begin acc = m * 512 + `PLC_K_BIT4; seg = 2; end
        else if (m[3]) begin acc = m * 1024 + `PLC_K_BIT3; seg = 1; end
        else begin acc = m * 3264; seg = 0; end
        out = (acc + 128) / 256;
        if (out > 256) out = 256;
        return {seg[2:0], out[8:0]};
    endfunction : plc_expect

endpackage : plc_tb_pkg

// file: plc_tick.sv
/*
 * sample-rate divider: one-cycle enable every DIV clock cycles.
 * assumes a single clock and an asynchronous active-low reset.
 */
`timescale 1ns/100ps
`include "plc_defines.svh"

module plc_tick #(
    parameter int DIV = `PLC_SAMPLE_DIV
) (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    // sample period enable
    output logic      tick_o
);
    localparam int CW = $clog2(DIV);

    logic [CW-1:0] count;

    if (DIV < 2) begin : g_bad_div
        $error("plc_tick: DIV must be at least 2");
    end

    // count down and pulse on wrap
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            count  <= '0;
            tick_o <= 1'b0;
        end else begin
            tick_o <= (count == '0);
            count  <= (count == '0) ? CW'(DIV - 1) : count - 1'b1;
        end
    end

endmodule : plc_tick
